/* verilog/als_range_conv.sv */
// Behaviour
// - The four-bit range_select field in bits 15:12 picks the full-scale range used by conversions.
// - Range codes share the result exponent encoding, so code n means LSB weight 0.01 lux times two to n.
// - Range code 1100b puts the block in automatic full-scale mode where it picks the range itself.
// - In automatic mode the range used for each conversion is written to the result exponent.
// - After reset range_select reads 1100b so the block starts in automatic mode.
// - conv_time_select in bit 11 gives a 100 ms conversion when zero and 800 ms when one.
// - The long conversion keeps full resolution on every range.
// - The short conversion keeps full resolution on ranges above 0101b.
// - The short conversion may lose one bit on 0101b, two on 0100b to 0001b and three on 0000b.
// - Result layout and LSB weight do not depend on the conversion time.
// - A configuration write aborts a running conversion and a new one starts if the settings ask for it.
// - In automatic mode an overflow below the top range aborts, steps up a range and restarts.
module als_range_conv #(
  parameter logic [23:0] CONV_SHORT_CYC = als_pkg::CYC_SHORT,
  parameter logic [23:0] CONV_LONG_CYC  = als_pkg::CYC_LONG
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [23:0] light_lux,
  output logic             conv_busy,
  output logic             conv_done
);
  import als_pkg::*;

  als_core_s   q;
  als_core_s   d;
  logic        cfg_wr;
  logic [23:0] len;
  logic        step_up;
  logic        last_cyc;
  logic [15:0] cfg_word;

  als_quant_if qif ();

  als_quant u_quant (
    .qif (qif.quant)
  );

  assign qif.light      = light_lux;
  assign qif.exp        = q.cur_rng;
  assign qif.short_conv = ~q.cur_ct;

  assign reg_rdata = q.rdata;
  assign conv_busy = (q.st == ALS_CONV);
  assign conv_done = q.done;

  ////////////////////////////////////////////////////////////////////////
  // Decode and conversion control
  always_comb begin
    cfg_wr   = reg_wr && (reg_addr == ADDR_CONFIG);
    len      = q.cur_ct ? CONV_LONG_CYC : CONV_SHORT_CYC;
    step_up  = q.cur_auto && qif.over && (q.cur_rng < RANGE_TOP);
    last_cyc = (q.cnt == len - 24'h1);
    cfg_word = '0;
    cfg_word[RANGE_MSB:RANGE_LSB] = q.range_select;
    cfg_word[CT_BIT]              = q.conv_time_select;
    cfg_word[MODE_MSB:MODE_LSB]   = q.mode;
    cfg_word[OVF_BIT]             = q.ovf;
    cfg_word[MISC_MSB:0]          = q.misc;

    d       = q;
    d.done  = 1'b0;
    d.rdata = '0;

    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_RESULT: d.rdata = {q.res_exp, q.res_mant};
        ADDR_CONFIG: d.rdata = cfg_word;
        default:     d.rdata = '0;
      endcase
    end

    unique case (q.st)
      ALS_IDLE: begin
        if (q.mode != MODE_SHUTDOWN) begin
          // Settings sampled only here
          d.st       = ALS_CONV;
          d.cnt      = '0;
          d.seen_ovf = 1'b0;
          d.cur_ct   = q.conv_time_select;
          d.cur_auto = (q.range_select == RANGE_AUTO);
          if (q.range_select == RANGE_AUTO) begin
            d.cur_rng = RANGE_BOTTOM;
          end else if (q.range_select > RANGE_TOP) begin
            d.cur_rng = RANGE_TOP;
          end else begin
            d.cur_rng = q.range_select;
          end
        end
      end
      ALS_CONV: begin
        if (step_up) begin
          d.cur_rng = q.cur_rng + 4'h1;
          d.cnt     = '0;
        end else if (last_cyc) begin
          d.st       = ALS_IDLE;
          d.done     = 1'b1;
          d.res_mant = qif.mant;
          d.ovf      = q.seen_ovf | qif.over;
          if (q.misc[MASK_EXP_BIT] && !q.cur_auto) begin
            d.res_exp = '0;
          end else begin
            d.res_exp = q.cur_rng;
          end
          if (q.mode == MODE_SINGLE) begin
            d.mode = MODE_SHUTDOWN;
          end
        end else begin
          d.cnt      = q.cnt + 24'h1;
          d.seen_ovf = q.seen_ovf | qif.over;
        end
      end
    endcase

    // Write wins over a finishing or stepping conversion for state, count and done, but a finishing result still loads
    if (cfg_wr) begin
      d.range_select     = reg_wdata[RANGE_MSB:RANGE_LSB];
      d.conv_time_select = reg_wdata[CT_BIT];
      d.mode             = reg_wdata[MODE_MSB:MODE_LSB];
      d.misc             = reg_wdata[MISC_MSB:0];
      d.st               = ALS_IDLE;
      d.cnt              = '0;
      d.done             = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      q                  <= '0;
      q.st               <= ALS_IDLE;
      q.range_select     <= RANGE_RESET;
      q.conv_time_select <= CT_RESET;
      q.mode             <= MODE_RESET;
      q.misc             <= MISC_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_auto_range: assert property (@(posedge clock) disable iff (srst)
    $fell(srst) |-> (q.range_select == RANGE_AUTO && q.conv_time_select))
    else $error("Range select not automatic after reset");

  a_cfg_write_abort: assert property (@(posedge clock) disable iff (srst)
    (cfg_wr && q.st == ALS_CONV) |=> (q.st == ALS_IDLE && !q.done))
    else $error("Configuration write did not abort conversion");

  a_restart_after_write: assert property (@(posedge clock) disable iff (srst)
    (cfg_wr && reg_wdata[MODE_MSB:MODE_LSB] != MODE_SHUTDOWN) ##1 !cfg_wr |=> (q.st == ALS_CONV && q.cnt == 24'h0))
    else $error("Conversion did not restart after write");

  a_auto_step_up: assert property (@(posedge clock) disable iff (srst)
    (q.st == ALS_CONV && step_up && !cfg_wr) |=> (q.cur_rng == $past(q.cur_rng) + 4'h1 && q.cnt == 24'h0))
    else $error("Automatic range did not step up on overflow");

  a_auto_exp_report: assert property (@(posedge clock) disable iff (srst)
    (q.st == ALS_CONV && last_cyc && !step_up && !cfg_wr && q.cur_auto) |=> (q.done && q.res_exp == $past(q.cur_rng)))
    else $error("Result exponent does not report chosen range");

  a_manual_range_use: assert property (@(posedge clock) disable iff (srst)
    (q.st == ALS_IDLE && q.mode != MODE_SHUTDOWN && q.range_select <= RANGE_TOP && !cfg_wr)
      |=> (q.cur_rng == $past(q.range_select) && !q.cur_auto))
    else $error("Programmed range not applied");

  a_conv_length: assert property (@(posedge clock) disable iff (srst)
    (q.st == ALS_CONV) |-> (q.cnt < (q.cur_ct ? CONV_LONG_CYC : CONV_SHORT_CYC)))
    else $error("Conversion ran past its length");

  a_settings_held: assert property (@(posedge clock) disable iff (srst)
    (q.st == ALS_CONV && $past(q.st) == ALS_CONV && !$past(cfg_wr)) |-> ($stable(q.cur_ct) && $stable(q.cur_auto)))
    else $error("Conversion settings changed mid conversion");

  a_short_low_range: assert property (@(posedge clock) disable iff (srst)
    (q.st == ALS_CONV && last_cyc && !step_up && !cfg_wr && !q.cur_ct && q.cur_rng == RANGE_BOTTOM)
      |=> (q.res_mant[2:0] == 3'h0))
    else $error("Short conversion kept too many bits");

  a_long_full_res: assert property (@(posedge clock) disable iff (srst)
    (q.st == ALS_CONV && last_cyc && !step_up && !cfg_wr && q.cur_ct && !qif.over)
      |=> (q.res_mant == $past(light_lux >> q.cur_rng)))
    else $error("Long conversion lost resolution");

  a_read_one_cycle: assert property (@(posedge clock) disable iff (srst)
    !reg_rd |=> (reg_rdata == 16'h0))
    else $error("Read data outside its cycle");

endmodule

/* verilog/als_pkg.sv */
package als_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register map and field layout of operating_configuration
  localparam logic [7:0]  ADDR_RESULT    = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG    = 8'h01;
  localparam int          RANGE_MSB      = 15;
  localparam int          RANGE_LSB      = 12;
  localparam int          CT_BIT         = 11;
  localparam int          MODE_MSB       = 10;
  localparam int          MODE_LSB       = 9;
  localparam int          OVF_BIT        = 8;
  localparam int          MISC_MSB       = 4;
  localparam int          MASK_EXP_BIT   = 2;
  localparam int          EXP_MSB        = 15;
  localparam int          EXP_LSB        = 12;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [15:0] CFG_RESET      = 16'hc810;
  localparam logic [3:0]  RANGE_RESET    = 4'hc;
  localparam logic [3:0]  RANGE_AUTO     = 4'hc;
  localparam logic [3:0]  RANGE_TOP      = 4'hb;
  localparam logic [3:0]  RANGE_BOTTOM   = 4'h0;
  localparam logic        CT_RESET       = 1'b1;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [1:0]  MODE_SHUTDOWN  = 2'h0;
  localparam logic [1:0]  MODE_SINGLE    = 2'h1;
  localparam logic [4:0]  MISC_RESET     = 5'h10;
  localparam logic [3:0]  RES_FULL_ABOVE = 4'h5;
  localparam logic [3:0]  RES_DROP2_LOW  = 4'h1;
  localparam logic [3:0]  RES_DROP2_HIGH = 4'h4;

  ////////////////////////////////////////////////////////////////////////
  // Conversion timing
  localparam longint unsigned CLK_HZ     = 64'd10_000_000;
  localparam longint unsigned T_SHORT_MS = 64'd100;
  localparam longint unsigned T_LONG_MS  = 64'd800;
  localparam logic [23:0] CYC_SHORT      = 24'(T_SHORT_MS * CLK_HZ / 64'd1000);
  localparam logic [23:0] CYC_LONG       = 24'(T_LONG_MS * CLK_HZ / 64'd1000);

  typedef enum logic {ALS_IDLE, ALS_CONV} als_state_e;

  typedef struct packed {
    als_state_e  st;
    logic [3:0]  range_select;
    logic        conv_time_select;
    logic [1:0]  mode;
    logic [4:0]  misc;
    logic        ovf;
    logic [3:0]  res_exp;
    logic [11:0] res_mant;
    logic [23:0] cnt;
    logic [3:0]  cur_rng;
    logic        cur_ct;
    logic        cur_auto;
    logic        seen_ovf;
    logic        done;
    logic [15:0] rdata;
  } als_core_s;

endpackage

/* verilog/als_quant_if.sv */
interface als_quant_if;
  logic [23:0] light;
  logic [3:0]  exp;
  logic        short_conv;
  logic [11:0] mant;
  logic        over;

  modport engine (output light, output exp, output short_conv, input mant, input over);
  modport quant  (input light, input exp, input short_conv, output mant, output over);
endinterface

/* verilog/als_quant.sv */
module als_quant (
  als_quant_if.quant qif
);
  import als_pkg::*;

  logic [23:0] shifted;
  logic [11:0] raw;
  logic [1:0]  drop;
  logic [11:0] keep;

  ////////////////////////////////////////////////////////////////////////
  // Scale to the range, saturate, then trim low bits on short conversions
  always_comb begin
    shifted = qif.light >> qif.exp;
    qif.over = |shifted[23:12];
    raw = qif.over ? 12'hfff : shifted[11:0];
    drop = 2'h0;
    if (qif.short_conv) begin
      if (qif.exp == RANGE_BOTTOM) begin
        drop = 2'h3;
      end else if (qif.exp >= RES_DROP2_LOW && qif.exp <= RES_DROP2_HIGH) begin
        drop = 2'h2;
      end else if (qif.exp == RES_FULL_ABOVE) begin
        drop = 2'h1;
      end else begin
        drop = 2'h0;
      end
    end
  end

  for (genvar i = 0; i < 12; i++) begin : g_keep
    assign keep[i] = (i >= int'(drop));
  end

  // Same layout and weight for both times, only low bits cleared
  assign qif.mant = raw & keep;

endmodule

/* test/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import als_pkg::*;

  localparam logic [23:0] SHORT_CYC = 24'd20;
  localparam logic [23:0] LONG_CYC  = 24'd40;

  logic        clock      = 1'b0;
  logic        srst       = 1'b1;
  logic [7:0]  reg_addr   = 8'h00;
  logic [15:0] reg_wdata  = 16'h0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [15:0] reg_rdata;
  logic [23:0] light_lux  = 24'h000000;
  logic        conv_busy;
  logic        conv_done;
  int          error_cnt  = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  int          nb;
  logic        sn;
  logic [15:0] rv;
  logic [11:0] m;

  ////////////////////////////////////////////////////////////////////////
  always #50 clock = ~clock;

  als_range_conv #(
    .CONV_SHORT_CYC (SHORT_CYC),
    .CONV_LONG_CYC  (LONG_CYC)
  ) uut (
    .clock     (clock),
    .srst      (srst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .light_lux (light_lux),
    .conv_busy (conv_busy),
    .conv_done (conv_done)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // Counts busy cycles until the done pulse, bounded
  task automatic wait_done(input int lim, output int nbusy, output logic seen);
    nbusy = 0;
    seen  = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(negedge clock);
      if (conv_busy === 1'b1) nbusy++;
      if (conv_done === 1'b1) seen = 1'b1;
    end
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      $display("[FAIL] timeout expected done seen hang");
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rd(ADDR_CONFIG, rv);
    chk("config reset", 16'hc810, rv);
    rd(ADDR_RESULT, rv);
    chk("result reset", 16'h0000, rv);
    rd(8'h05, rv);
    chk("unmapped read", 16'h0000, rv);
    $display("test reset done");

    // Codes 0 to 11 only
    for (int r = 0; r < 12; r++) begin
      for (int t = 0; t < 2; t++) begin
        light_lux <= 24'h000777 << r;
        wr(ADDR_CONFIG, {4'(r), 1'(t), MODE_SINGLE, 9'h000});
        wait_done(200, nb, sn);
        chk("done seen", 16'h0001, {15'h0, sn});
        chk("busy cycles", t ? LONG_CYC[15:0] : SHORT_CYC[15:0], 16'(nb));
        m = 12'h777;
        if (t == 0) m = (r == 0) ? 12'h770 : (r < 5) ? 12'h774 : (r == 5) ? 12'h776 : 12'h777;
        rd(ADDR_RESULT, rv);
        chk("manual result", {4'(r), m}, rv);
        rd(ADDR_CONFIG, rv);
        chk("config after single", {4'(r), 1'(t), MODE_SHUTDOWN, 9'h000}, rv);
      end
    end
    $display("test manual ranges done");

    light_lux <= 24'h005000;
    wr(ADDR_CONFIG, {RANGE_AUTO, 1'b0, MODE_SINGLE, 9'h000});
    wait_done(300, nb, sn);
    chk("auto done", 16'h0001, {15'h0, sn});
    rd(ADDR_RESULT, rv);
    chk("auto result", 16'h3a00, rv);
    rd(ADDR_CONFIG, rv);
    chk("auto no overflow", {RANGE_AUTO, 1'b0, MODE_SHUTDOWN, 9'h000}, rv);
    light_lux <= 24'hffffff;
    wr(ADDR_CONFIG, {RANGE_AUTO, 1'b1, MODE_SINGLE, 9'h000});
    wait_done(300, nb, sn);
    rd(ADDR_RESULT, rv);
    chk("auto top result", 16'hbfff, rv);
    rd(ADDR_CONFIG, rv);
    chk("auto overflow", {RANGE_AUTO, 1'b1, MODE_SHUTDOWN, 1'b1, 8'h00}, rv);
    $display("test auto range done");

    light_lux <= 24'h000100;
    wr(ADDR_CONFIG, {4'h2, 1'b1, MODE_SINGLE, 9'h000});
    repeat (10) @(posedge clock);
    wr(ADDR_CONFIG, {4'h4, 1'b0, MODE_SINGLE, 9'h000});
    wait_done(300, nb, sn);
    chk("restart done", 16'h0001, {15'h0, sn});
    rd(ADDR_RESULT, rv);
    chk("restart result", 16'h4010, rv);
    wr(ADDR_CONFIG, {4'h2, 1'b1, MODE_SINGLE, 9'h000});
    repeat (10) @(posedge clock);
    wr(ADDR_CONFIG, {4'h2, 1'b1, MODE_SHUTDOWN, 9'h000});
    wait_done(100, nb, sn);
    chk("no done after abort", 16'h0000, {15'h0, sn});
    rd(ADDR_RESULT, rv);
    chk("result kept", 16'h4010, rv);
    $display("test abort done");

    // Continuous mode with exponent mask on a manual range
    wr(ADDR_CONFIG, {4'h3, 1'b0, 2'h2, 9'h004});
    wait_done(100, nb, sn);
    chk("cont first done", 16'h0001, {15'h0, sn});
    wait_done(100, nb, sn);
    chk("cont second done", 16'h0001, {15'h0, sn});
    chk("cont busy cycles", SHORT_CYC[15:0], 16'(nb));
    rd(ADDR_RESULT, rv);
    chk("masked result", 16'h0020, rv);
    rd(ADDR_CONFIG, rv);
    chk("cont mode kept", {4'h3, 1'b0, 2'h2, 9'h004}, rv);
    wr(ADDR_CONFIG, {4'h3, 1'b0, MODE_SHUTDOWN, 9'h004});
    wait_done(60, nb, sn);
    chk("cont stopped", 16'h0000, {15'h0, sn});
    $display("test continuous done");
    test_done();
  end
endmodule
